// File: hw/ddsc_defines.svh
// constants of the dual dac serial command port
//
// Functional notes
// [R1] shift only while chip select low
// [R2] sample data on serial clock rise
// [R3] host sends 16 bits, msb first
// [R4] bursts may split a command, select held
// [R5] execute on chip select rise after 16
// [R6] one register per channel, no buffering
// [R7] each control bit acts on its own
// [R8] wire order: spares, sd b/a, spare, loads, data
// [R9] load a copies data to channel a
// [R10] load b copies data to channel b
// [R11] no load bits leaves registers unchanged
// [R12] shutdown a bit sets channel a state
// [R13] shutdown b bit sets channel b state
// [R14] loads and shutdowns apply together
// [R15] output equals code over 256 of reference
// [R16] host writes once after power-up
// [R17] host idles clock low, changes on fall
// [R18] host toggles clock only while sending
// [R19] shutdown keeps register, output inactive
// [R20] leaving shutdown restores register output
// [R21] host sends spare 3 one, spare 4 zero; ddsc_host sends the written bits unchanged and forces neither
`ifndef DDSC_DEFINES_SVH
`define DDSC_DEFINES_SVH
`define DDSC_WORD_BITS   5'd16
`define DDSC_POS_SPARE_1 15
`define DDSC_POS_SPARE_2 14
`define DDSC_POS_SPARE_3 13
`define DDSC_POS_SD_B    12
`define DDSC_POS_SD_A    11
`define DDSC_POS_SPARE_4 10
`define DDSC_POS_LOAD_B  9
`define DDSC_POS_LOAD_A  8
`define DDSC_HALF_SCLK   8'd4
`define DDSC_ADDR_CMD    32'h0000_0000
`define DDSC_ADDR_STAT   32'h0000_0004
`define DDSC_ADDR_MIRROR 32'h0000_0008
`endif

// File: hw/ddsc_pkg.sv
// types of the dual dac serial command port
package ddsc_pkg;
  typedef enum logic [3:0] {
    DDSC_IDLE  = 4'b0001,
    DDSC_SETUP = 4'b0010,
    DDSC_SHIFT = 4'b0100,
    DDSC_HOLD  = 4'b1000
  } ddsc_state_t;
  function automatic logic [7:0] ddsc_volts(input logic [7:0] code, input logic shut, input logic [7:0] ref_v);
    logic [15:0] prod;
    prod = 16'(code) * 16'(ref_v);
    ddsc_volts = shut ? 8'h00 : prod[15:8];
  endfunction : ddsc_volts
endpackage : ddsc_pkg

// File: hw/ddsc_link_if.sv
// three-wire link between host and dac
`timescale 1ns/1ps
interface ddsc_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  modport host (output cs_n, output sclk, output din);
  modport dev  (input  cs_n, input  sclk, input  din);
endinterface : ddsc_link_if

// File: hw/ddsc_sync.sv
// two-flop synchroniser with edge detect on the second stage
`timescale 1ns/1ps
module ddsc_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end
  assign level_o = sync_ff;
  assign rise_o  = sync_ff & ~last_ff;
  assign fall_o  = ~sync_ff & last_ff;
endmodule : ddsc_sync

// File: hw/ddsc_dev.sv
// dac end: serial command receiver, channel registers and output codes
`timescale 1ns/1ps
`include "ddsc_defines.svh"
module ddsc_dev
  import ddsc_pkg::*;
(
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  ddsc_link_if.dev    link,
  input  wire logic [7:0] ref_i,
  output logic [7:0]  chan_a_voltage_o,
  output logic [7:0]  chan_b_voltage_o,
  output logic [7:0]  chan_a_code_o,
  output logic [7:0]  chan_b_code_o,
  output logic        shutdown_chan_a_o,
  output logic        shutdown_chan_b_o,
  output logic        cmd_done_o
);
  logic        cs_lvl;
  logic        cs_rise;
  logic        sclk_rise;
  logic        din_lvl;
  logic [15:0] shift_ff;
  logic [4:0]  count_ff;
  logic [7:0]  reg_a_ff;
  logic [7:0]  reg_b_ff;
  logic        sd_a_ff;
  logic        sd_b_ff;
  logic        done_ff;
  logic [7:0]  volt_a_ff;
  logic [7:0]  volt_b_ff;
  logic        exec;

  ddsc_sync u_cs   (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .async_i(link.cs_n),
                    .level_o(cs_lvl), .rise_o(cs_rise), .fall_o());
  ddsc_sync u_sclk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .async_i(link.sclk),
                    .level_o(), .rise_o(sclk_rise), .fall_o());
  ddsc_sync u_din  (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .async_i(link.din),
                    .level_o(din_lvl), .rise_o(), .fall_o());

  // shifting continues across burst gaps while select stays low
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_ff <= 16'h0000;
      count_ff <= 5'h00;
    end else if (cs_lvl) begin
      count_ff <= 5'h00;                             // [R1]
    end else if (sclk_rise) begin
      shift_ff <= {shift_ff[14:0], din_lvl};         // [R2] [R4] [R8]
      if (count_ff != `DDSC_WORD_BITS) begin
        count_ff <= count_ff + 5'h01;
      end
    end
  end

  assign exec = cs_rise && (count_ff == `DDSC_WORD_BITS); // [R5]

  // single register per channel; each control bit decoded alone
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_a_ff <= 8'h00;
      reg_b_ff <= 8'h00;
      sd_a_ff  <= 1'b0;
      sd_b_ff  <= 1'b0;
    end else if (exec) begin                         // [R14] [R6] [R7]
      if (shift_ff[`DDSC_POS_LOAD_A]) begin
        reg_a_ff <= shift_ff[7:0];                   // [R9]
      end
      if (shift_ff[`DDSC_POS_LOAD_B]) begin
        reg_b_ff <= shift_ff[7:0];                   // [R10] [R11]
      end
      sd_a_ff <= shift_ff[`DDSC_POS_SD_A];           // [R12]
      sd_b_ff <= shift_ff[`DDSC_POS_SD_B];           // [R13]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      volt_a_ff <= 8'h00;
      volt_b_ff <= 8'h00;
      done_ff   <= 1'b0;
    end else begin
      volt_a_ff <= ddsc_volts(reg_a_ff, sd_a_ff, ref_i); // [R15] [R19] [R20]
      volt_b_ff <= ddsc_volts(reg_b_ff, sd_b_ff, ref_i); // [R15] [R19] [R20]
      done_ff   <= exec;
    end
  end

  assign chan_a_voltage_o  = volt_a_ff;
  assign chan_b_voltage_o  = volt_b_ff;
  assign chan_a_code_o     = reg_a_ff;
  assign chan_b_code_o     = reg_b_ff;
  assign shutdown_chan_a_o = sd_a_ff;
  assign shutdown_chan_b_o = sd_b_ff;
  assign cmd_done_o        = done_ff;
endmodule : ddsc_dev

// File: hw/ddsc_host.sv
// host end: axi4-lite command registers driving the three-wire link
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ddsc_defines.svh"
module ddsc_host
  import ddsc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  ddsc_link_if.host        link,
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);
  logic        aw_ff;
  logic [31:0] awaddr_ff;
  logic        w_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [15:0] word_ff;
  logic [15:0] last_ff;
  logic [15:0] cmd_ff;
  logic        start;
  ddsc_state_t state_ff;
  logic [7:0]  tick_ff;
  logic [4:0]  bits_ff;
  logic        cs_n_ff;
  logic        sclk_ff;
  logic        din_ff;
  logic        do_write;
  logic        cmd_hit;
  logic        busy;

  // end of one half period of the serial clock
  function automatic logic half_done(input logic [7:0] t);
    half_done = (t == `DDSC_HALF_SCLK);
  endfunction : half_done

  assign busy            = (state_ff != DDSC_IDLE);
  assign s_axi_awready_o = ~aw_ff & ~bvalid_ff;
  assign s_axi_wready_o  = ~w_ff & ~bvalid_ff;
  assign s_axi_arready_o = ~rvalid_ff;
  assign do_write        = aw_ff & w_ff & ~bvalid_ff;
  assign cmd_hit         = (awaddr_ff == `DDSC_ADDR_CMD);
  // a command write while busy is refused with slverr
  assign start           = do_write & cmd_hit & ~busy & (&wstrb_ff[1:0]);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_ff     <= 1'b0;
      awaddr_ff <= 32'h0000_0000;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_ff     <= 1'b1;
      awaddr_ff <= s_axi_awaddr_i;
    end else if (do_write) begin
      aw_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      w_ff     <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_ff     <= 1'b1;
      wdata_ff <= s_axi_wdata_i;
      wstrb_ff <= s_axi_wstrb_i;
    end else if (do_write) begin
      w_ff <= 1'b0;
    end
  end

  // response waits until both address and data are held
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'h0;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= start ? 2'h0 : 2'h2;
    end else if (bvalid_ff && s_axi_bready_i) begin
      bvalid_ff <= 1'b0;
    end
  end

  // the word in flight is kept apart, so a refused write cannot spoil the mirror
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_ff  <= 16'h0000;
      last_ff <= 16'h0000;
    end else if (start) begin
      cmd_ff <= wdata_ff[15:0];
    end else if ((state_ff == DDSC_HOLD) && half_done(tick_ff)) begin
      last_ff <= cmd_ff;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= 2'h0;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= 2'h0;
      case (s_axi_araddr_i)
        `DDSC_ADDR_CMD:    rdata_ff <= {16'h0000, word_ff};
        `DDSC_ADDR_STAT:   rdata_ff <= {31'h0000_0000, busy};
        `DDSC_ADDR_MIRROR: rdata_ff <= {16'h0000, last_ff};
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= 2'h2;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready_i) begin
      rvalid_ff <= 1'b0;
    end
  end

  // spi mode 0 shifter: clock idles low, data changes on the falling edge
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= DDSC_IDLE;
      tick_ff  <= 8'h00;
      bits_ff  <= 5'h00;
      word_ff  <= 16'h0000;
      cs_n_ff  <= 1'b1;
      sclk_ff  <= 1'b0;                              // [R17] [R18]
      din_ff   <= 1'b0;
    end else begin
      case (state_ff)
        DDSC_IDLE: begin
          if (start) begin
            word_ff  <= wdata_ff[15:0];              // [R21]
            cs_n_ff  <= 1'b0;
            tick_ff  <= 8'h00;
            bits_ff  <= 5'h00;
            din_ff   <= wdata_ff[15];                // [R3] [R8]
            state_ff <= DDSC_SETUP;
          end
        end
        DDSC_SETUP: begin
          if (half_done(tick_ff)) begin
            tick_ff  <= 8'h00;
            sclk_ff  <= 1'b1;                        // [R2]
            state_ff <= DDSC_SHIFT;
          end else begin
            tick_ff <= tick_ff + 8'h01;
          end
        end
        DDSC_SHIFT: begin
          if (half_done(tick_ff)) begin
            tick_ff <= 8'h00;
            sclk_ff <= 1'b0;
            bits_ff <= bits_ff + 5'h01;
            word_ff <= {word_ff[14:0], 1'b0};
            if (bits_ff == `DDSC_WORD_BITS - 5'd1) begin
              state_ff <= DDSC_HOLD;
            end else begin
              din_ff   <= word_ff[14];               // [R3]
              state_ff <= DDSC_SETUP;
            end
          end else begin
            tick_ff <= tick_ff + 8'h01;
          end
        end
        DDSC_HOLD: begin
          if (half_done(tick_ff)) begin
            cs_n_ff  <= 1'b1;                        // [R5]
            state_ff <= DDSC_IDLE;
          end else begin
            tick_ff <= tick_ff + 8'h01;
          end
        end
        default: state_ff <= DDSC_IDLE;
      endcase
    end
  end

  assign link.cs_n      = cs_n_ff;
  assign link.sclk      = sclk_ff;
  assign link.din       = din_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o  = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o  = rdata_ff;
  assign s_axi_rresp_o  = rresp_ff;
endmodule : ddsc_host

// File: testbench/ddsc_link_props.sv
// checker for the three-wire link and the dac end outputs
`timescale 1ns/1ps
module ddsc_link_props (
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       din,
  input wire logic [7:0] ref_i,
  input wire logic [7:0] chan_a_code_o,
  input wire logic [7:0] chan_b_code_o,
  input wire logic [7:0] chan_a_voltage_o,
  input wire logic       shutdown_chan_a_o,
  input wire logic       shutdown_chan_b_o,
  input wire logic       cmd_done_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence clk_low_hold;
    !sclk[*4];
  endsequence
  sequence clk_high_hold;
    sclk[*4];
  endsequence
  clk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock active while deselected");
  din_steady_a: assert property ($rose(sclk) |-> $stable(din))
    else $error("data moved at serial clock rise");
  clk_high_a: assert property ($rose(sclk) |-> clk_high_hold)
    else $error("serial clock high phase too short");
  sel_setup_a: assert property ($fell(cs_n) |-> clk_low_hold)
    else $error("clock rose too soon after select");
  exec_on_rise_a: assert property ($rose(cs_n) |-> ##[2:10] cmd_done_o)
    else $error("command not executed after select rise");
  done_deselect_a: assert property (cmd_done_o |-> cs_n)
    else $error("execution while selected");
  code_change_a: assert property ($changed({chan_a_code_o, chan_b_code_o}) |-> cmd_done_o)
    else $error("channel code changed outside execution");
  shut_change_a: assert property ($changed({shutdown_chan_a_o, shutdown_chan_b_o}) |-> cmd_done_o)
    else $error("shutdown changed outside execution");
  volt_a_a: assert property (1'b1 |=> chan_a_voltage_o == ($past(shutdown_chan_a_o) ? 8'h00 :
    8'((16'($past(chan_a_code_o)) * 16'($past(ref_i))) >> 8))) else $error("channel a output wrong");
endmodule : ddsc_link_props

// File: testbench/testbench.sv
// self-checking bench joining host end and dac end over the link
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [31:0] awaddr    = 32'h0;
  logic [31:0] wdata     = 32'h0;
  logic [31:0] araddr    = 32'h0;
  logic        awvalid   = 1'b0;
  logic        wvalid    = 1'b0;
  logic        arvalid   = 1'b0;
  logic [7:0]  ref_v     = 8'hC8;
  logic [3:0]  wstrb     = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid, sd_a, sd_b, done;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0]  code_a, code_b, volt_a, volt_b;
  logic [33:0] rows [8];
  int          failures    = 0;
  int          checks_done = 0;
  ddsc_link_if i_link ();
  always #25 sys_clk_i = ~sys_clk_i;
  ddsc_host i_ddsc_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(i_link.host), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1));
  ddsc_dev i_ddsc_dev (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(i_link.dev), .ref_i(ref_v),
    .chan_a_voltage_o(volt_a), .chan_b_voltage_o(volt_b), .chan_a_code_o(code_a), .chan_b_code_o(code_b),
    .shutdown_chan_a_o(sd_a), .shutdown_chan_b_o(sd_b), .cmd_done_o(done));
  ddsc_link_props i_ddsc_link_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cs_n(i_link.cs_n),
    .sclk(i_link.sclk), .din(i_link.din), .ref_i(ref_v), .chan_a_code_o(code_a), .chan_b_code_o(code_b),
    .chan_a_voltage_o(volt_a), .shutdown_chan_a_o(sd_a), .shutdown_chan_b_o(sd_b), .cmd_done_o(done));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  // one clock of a bounded wait
  task automatic tick(inout int n);
    @(posedge sys_clk_i);
    n++;
    if (n > 600) begin
      failures++;
      $display("MISMATCH wait expected answer seen none");
      test_done();
    end
  endtask : tick
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      tick(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      tick(n);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
  endtask : axi_rd
  task automatic wait_cmd();
    int n;
    n = 0;
    do tick(n); while (!done);
    repeat (2) @(posedge sys_clk_i);
  endtask : wait_cmd
  function automatic logic [7:0] volts(input logic [7:0] c, input logic s);
    volts = s ? 8'h00 : 8'((16'(c) * 16'(ref_v)) >> 8);
  endfunction : volts
  // row: command word, code a, code b, shutdown a, shutdown b
  task automatic chk_out(input logic [33:0] r);
    `CHK("code a", r[17:10], code_a)
    `CHK("code b", r[9:2], code_b)
    `CHK("shut a", r[1], sd_a)
    `CHK("shut b", r[0], sd_b)
    `CHK("volt a", volts(r[17:10], r[1]), volt_a)
    `CHK("volt b", volts(r[9:2], r[0]), volt_b)
  endtask : chk_out
  initial begin
    rows = '{{16'h2380, 8'h80, 8'h80, 2'h0}, {16'h21FF, 8'hFF, 8'h80, 2'h0}, {16'h2201, 8'hFF, 8'h01, 2'h0},
             {16'h2855, 8'hFF, 8'h01, 2'h2}, {16'h3140, 8'h40, 8'h01, 2'h1}, {16'h3800, 8'h40, 8'h01, 2'h3},
             {16'h2000, 8'h40, 8'h01, 2'h0}, {16'hE37F, 8'h7F, 8'h7F, 2'h0}};
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      axi_wr(32'h0, {16'h0, rows[i][33:18]});
      `CHK("bresp", 2'h0, resp)
      wait_cmd();
      chk_out(rows[i]);
      axi_rd(32'h8);
      `CHK("last word", rows[i][33:18], rd[15:0])
      $display("row %0d done", i);
    end
    // a second command while the first is still shifting is refused
    axi_wr(32'h0, 32'h2311);
    axi_wr(32'h0, 32'h2322);
    `CHK("busy bresp", 2'h2, resp)
    axi_rd(32'h4);
    `CHK("busy flag", 32'h1, rd)
    wait_cmd();
    chk_out({16'h2311, 8'h11, 8'h11, 2'h0});
    axi_rd(32'h4);
    `CHK("idle flag", 32'h0, rd)
    axi_rd(32'h8);
    `CHK("kept word", 16'h2311, rd[15:0])
    $display("busy write done");
    axi_wr(32'h4, 32'h2355);
    `CHK("ro bresp", 2'h2, resp)
    wstrb <= 4'h4;
    axi_wr(32'h0, 32'h2355);
    `CHK("strobe bresp", 2'h2, resp)
    wstrb <= 4'hF;
    axi_rd(32'hC);
    `CHK("unmapped rresp", 2'h2, resp)
    `CHK("unmapped data", 32'h0, rd)
    repeat (200) @(posedge sys_clk_i);
    `CHK("code kept", 8'h11, code_a)
    $display("refusal test done");
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    `CHK("reset select", 1'b1, i_link.cs_n)
    `CHK("reset clock", 1'b0, i_link.sclk)
    `CHK("reset code", 8'h00, code_a)
    rst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    `CHK("idle select", 1'b1, i_link.cs_n)
    axi_wr(32'h0, 32'h2A5A);
    wait_cmd();
    chk_out({16'h2A5A, 8'h00, 8'h5A, 2'h2});
    $display("reset test done");
    test_done();
  end
endmodule : testbench
